/* File: src/scr_synth_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module scr_synth_regs
  import scr_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // serial programming port
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_ENABLE_N_I,
  // configuration and reference pins
  input wire logic MODE_I,
  input wire logic MAIN_REF_RATE_I,
  // general purpose pins
  output logic OUT_A_O,
  output logic [1:0] OUT_A_MUX_O,
  output logic OUT_B_O,
  output logic OUT_B_OE_O,
  output logic OUT_C_O,
  output logic OUT_C_OE_O,
  // detector output enables
  output logic MAIN_PUMP_HIGH_OE_O,
  output logic MAIN_PUMP_LOW_OE_O,
  output logic SECONDARY_PUMP_OE_O,
  // standby and reference mode
  output logic OSC_STANDBY_O,
  output logic MAIN_STANDBY_O,
  output logic SECONDARY_STANDBY_O,
  output logic EXT_REF_MODE_O,
  // active dividers and settings
  output logic [17:0] MAIN_DIV_O,
  output logic [15:0] MAIN_REF_DIV_O,
  output logic [15:0] SECONDARY_DIV_O,
  output logic [23:0] SECONDARY_REF_O,
  output logic [15:0] DAC_VALUES_O,
  output logic [7:0] LOCK_WINDOW_O,
  output logic [3:0] CURRENT_RATIO_O,
  output logic [4:0] AUX_RATIO_X2_O,
  output logic AUX_POLARITY_IN_O
);

  // ----------------------------------------------------------------
  // serial receiver and frame decode
  // ----------------------------------------------------------------
  scr_ser_if ser ();

  scr_serial_rx u_rx (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .ser_clk_i(SER_CLK_I),
    .ser_data_i(SER_DATA_I),
    .ser_enable_n_i(SER_ENABLE_N_I),
    .frame(ser.rx)
  );

  // register picked by an addressed frame, checked against its width
  function automatic scr_sel_t addr_sel(input logic [3:0] adr, input logic [5:0] dlen);
    scr_sel_t s;
    s = SCR_SEL_NONE;
    case (adr)
      SCR_ADR_CTRL: if (dlen == SCR_LEN_C) s = SCR_SEL_CTRL;
      SCR_ADR_DAC: if (dlen == SCR_LEN_16) s = SCR_SEL_DAC;
      SCR_ADR_SDIV_HOLD: if (dlen == SCR_LEN_16) s = SCR_SEL_SDIV_HOLD;
      SCR_ADR_MREF_HOLD: if (dlen == SCR_LEN_16) s = SCR_SEL_MREF_HOLD;
      SCR_ADR_SREF: if (dlen == SCR_LEN_32) s = SCR_SEL_SREF;
      SCR_ADR_MDIV: if (dlen == SCR_LEN_24) s = SCR_SEL_MDIV;
      default: s = SCR_SEL_NONE;
    endcase
    return s;
  endfunction

  // register picked by a short frame, by length alone
  function automatic scr_sel_t len_sel(input logic [5:0] len);
    scr_sel_t s;
    case (len)
      SCR_LEN_C: s = SCR_SEL_CTRL;
      SCR_LEN_16: s = SCR_SEL_MREF_HOLD;
      SCR_LEN_24: s = SCR_SEL_MDIV;
      SCR_LEN_32: s = SCR_SEL_SREF;
      default: s = SCR_SEL_NONE;
    endcase
    return s;
  endfunction

  logic addressed;
  logic [5:0] dlen;
  logic [31:0] wdata;
  scr_sel_t sel;

  always_comb begin
    addressed = (ser.len[1:0] == 2'b00) && (ser.len[2] == 1'b1);
    dlen = ser.len - SCR_LEN_ADDR;
    if (addressed) begin
      wdata = ser.bits[SCR_FRAME_W-1:SCR_ADDR_W];
      sel = addr_sel(ser.bits[SCR_ADDR_W-1:0], dlen);
    end else begin
      wdata = ser.bits[31:0];
      sel = len_sel(ser.len);
    end
    if (!ser.done) begin
      sel = SCR_SEL_NONE;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [15:0] mref_hold_r, mref_hold_nxt;
  logic [23:0] mdiv_r, mdiv_nxt;
  logic [23:0] sref_r, sref_nxt;
  logic [15:0] sdiv_hold_r, sdiv_hold_nxt;
  logic [15:0] dac_r, dac_nxt;
  logic [15:0] mref_act_r, mref_act_nxt;
  logic [15:0] sdiv_act_r, sdiv_act_nxt;
  logic boost_start;

  // write decode; a bad length or address leaves every register alone
  always_comb begin
    ctrl_nxt = ctrl_r;
    mref_hold_nxt = mref_hold_r;
    mdiv_nxt = mdiv_r;
    sref_nxt = sref_r;
    sdiv_hold_nxt = sdiv_hold_r;
    dac_nxt = dac_r;
    mref_act_nxt = mref_act_r;
    sdiv_act_nxt = sdiv_act_r;
    boost_start = 1'b0;
    case (sel)
      SCR_SEL_CTRL: ctrl_nxt = wdata[7:0];
      SCR_SEL_DAC: dac_nxt = wdata[15:0];
      SCR_SEL_SREF: sref_nxt = wdata[23:0];
      SCR_SEL_MREF_HOLD: mref_hold_nxt = wdata[15:0];
      SCR_SEL_SDIV_HOLD: sdiv_hold_nxt = wdata[15:0];
      SCR_SEL_MDIV: begin
        mdiv_nxt = wdata[23:0];
        mref_act_nxt = mref_hold_r;
        sdiv_act_nxt = sdiv_hold_r;
        boost_start = wdata[SCR_N_PROG_LO+2];
      end
      SCR_SEL_NONE: ctrl_nxt = ctrl_r;
      default: ctrl_nxt = ctrl_r;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r <= SCR_C_RESET;
      mref_hold_r <= SCR_HOLD_RESET;
      mdiv_r <= SCR_N_RESET;
      sref_r <= SCR_SREF_RESET;
      sdiv_hold_r <= SCR_HOLD_RESET;
      dac_r <= SCR_HOLD_RESET;
      mref_act_r <= SCR_HOLD_RESET;
      sdiv_act_r <= SCR_HOLD_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      mref_hold_r <= mref_hold_nxt;
      mdiv_r <= mdiv_nxt;
      sref_r <= sref_nxt;
      sdiv_hold_r <= sdiv_hold_nxt;
      dac_r <= dac_nxt;
      mref_act_r <= mref_act_nxt;
      sdiv_act_r <= sdiv_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // timed high current phase
  // ----------------------------------------------------------------
  logic high_phase;
  logic [7:0] boost_cycles;

  // 16, 32, 64 or 128 reference cycles
  assign boost_cycles = SCR_BOOST_BASE << wdata[SCR_N_PROG_LO+1 -: 2];

  scr_boost_timer u_boost (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .start_i(boost_start),
    .cycles_i(boost_cycles),
    .ref_i(MAIN_REF_RATE_I),
    .high_phase_o(high_phase)
  );

  // ----------------------------------------------------------------
  // mode pin synchroniser
  // ----------------------------------------------------------------
  logic mode_s1_r, mode_s2_r;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      mode_s1_r <= MODE_I;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  logic [2:0] prog;
  logic hi_en, lo_en, aux_low;
  logic [1:0] mux;
  logic out_a_nxt, out_b_nxt, out_b_oe_nxt, out_c_oe_nxt;
  logic hi_oe_nxt, lo_oe_nxt, sec_oe_nxt, ext_nxt;
  logic [7:0] win_nxt;
  logic [3:0] ratio_nxt;
  logic [4:0] aux_nxt;

  always_comb begin
    prog = mdiv_r[SCR_N_PROG_LO+2:SCR_N_PROG_LO];
    mux = sref_r[SCR_SREF_MUX_LO+1:SCR_SREF_MUX_LO];
    out_a_nxt = (mux == SCR_MUX_GPO) ? ctrl_r[SCR_C_OUT_A] : 1'b0;
    out_b_oe_nxt = ~ctrl_r[SCR_C_MAIN_STBY];
    out_b_nxt = ctrl_r[SCR_C_OUT_B_XREF];
    out_c_oe_nxt = ~ctrl_r[SCR_C_OUT_C];
    hi_en = prog[1];
    lo_en = prog[0];
    if (prog[2]) begin
      hi_en = high_phase;
      lo_en = ~high_phase;
    end
    // float forces release; standby also idles the pumps
    hi_oe_nxt = hi_en & ~ctrl_r[SCR_C_MAIN_FLOAT] & ~ctrl_r[SCR_C_MAIN_STBY];
    lo_oe_nxt = lo_en & ~ctrl_r[SCR_C_MAIN_FLOAT] & ~ctrl_r[SCR_C_MAIN_STBY];
    sec_oe_nxt = ~ctrl_r[SCR_C_SEC_FLOAT] & ~ctrl_r[SCR_C_SEC_STBY];
    ext_nxt = mode_s2_r & ctrl_r[SCR_C_OUT_B_XREF];
    win_nxt = mdiv_r[SCR_N_WINDOW] ? SCR_WIN_LONG : SCR_WIN_SHORT;
    ratio_nxt = mdiv_r[SCR_N_RATIO] ? SCR_RATIO_HIGH : SCR_RATIO_LOW;
    aux_low = (sref_r[1:0] == 2'b00);
    if (mdiv_r[SCR_N_AUX_TOP]) begin
      aux_nxt = aux_low ? SCR_AUX_X2_8 : SCR_AUX_X2_10;
    end else begin
      aux_nxt = aux_low ? SCR_AUX_X2_10 : SCR_AUX_X2_12P5;
    end
  end

  // output flops; reset matches the power-up register values
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      OUT_A_O <= 1'b0;
      OUT_A_MUX_O <= 2'h0;
      OUT_B_O <= 1'b0;
      OUT_B_OE_O <= 1'b0;
      OUT_C_O <= 1'b0;
      OUT_C_OE_O <= 1'b1;
      MAIN_PUMP_HIGH_OE_O <= 1'b0;
      MAIN_PUMP_LOW_OE_O <= 1'b0;
      SECONDARY_PUMP_OE_O <= 1'b0;
      OSC_STANDBY_O <= 1'b0;
      MAIN_STANDBY_O <= 1'b1;
      SECONDARY_STANDBY_O <= 1'b1;
      EXT_REF_MODE_O <= 1'b0;
      MAIN_DIV_O <= 18'h00000;
      MAIN_REF_DIV_O <= 16'h0000;
      SECONDARY_DIV_O <= 16'h0000;
      SECONDARY_REF_O <= 24'h000000;
      DAC_VALUES_O <= 16'h0000;
      LOCK_WINDOW_O <= SCR_WIN_SHORT;
      CURRENT_RATIO_O <= SCR_RATIO_LOW;
      AUX_RATIO_X2_O <= SCR_AUX_X2_10;
      AUX_POLARITY_IN_O <= 1'b0;
    end else begin
      OUT_A_O <= out_a_nxt;
      OUT_A_MUX_O <= mux;
      OUT_B_O <= out_b_nxt;
      OUT_B_OE_O <= out_b_oe_nxt;
      OUT_C_O <= 1'b0;
      OUT_C_OE_O <= out_c_oe_nxt;
      MAIN_PUMP_HIGH_OE_O <= hi_oe_nxt;
      MAIN_PUMP_LOW_OE_O <= lo_oe_nxt;
      SECONDARY_PUMP_OE_O <= sec_oe_nxt;
      OSC_STANDBY_O <= ctrl_r[SCR_C_OSC_STBY];
      MAIN_STANDBY_O <= ctrl_r[SCR_C_MAIN_STBY];
      SECONDARY_STANDBY_O <= ctrl_r[SCR_C_SEC_STBY];
      EXT_REF_MODE_O <= ext_nxt;
      MAIN_DIV_O <= mdiv_r[SCR_N_DIV_W-1:0];
      MAIN_REF_DIV_O <= mref_act_r;
      SECONDARY_DIV_O <= sdiv_act_r;
      SECONDARY_REF_O <= sref_r;
      DAC_VALUES_O <= dac_r;
      LOCK_WINDOW_O <= win_nxt;
      CURRENT_RATIO_O <= ratio_nxt;
      AUX_RATIO_X2_O <= aux_nxt;
      AUX_POLARITY_IN_O <= mode_s2_r;
    end
  end

endmodule
`default_nettype wire

/* File: include/scr_pkg.sv */
package scr_pkg;

  // ----------------------------------------------------------------
  // register widths and serial frame lengths
  // ----------------------------------------------------------------
  localparam int SCR_FRAME_W = 36;
  localparam int SCR_LEN_W = 6;
  localparam int SCR_ADDR_W = 4;
  localparam logic [5:0] SCR_LEN_C = 6'h08;
  localparam logic [5:0] SCR_LEN_16 = 6'h10;
  localparam logic [5:0] SCR_LEN_24 = 6'h18;
  localparam logic [5:0] SCR_LEN_32 = 6'h20;
  localparam logic [5:0] SCR_LEN_ADDR = 6'h04;

  // ----------------------------------------------------------------
  // register address codes for the addressed load format
  // ----------------------------------------------------------------
  localparam logic [3:0] SCR_ADR_CTRL = 4'h1;
  localparam logic [3:0] SCR_ADR_DAC = 4'h2;
  localparam logic [3:0] SCR_ADR_SDIV_HOLD = 4'h3;
  localparam logic [3:0] SCR_ADR_MREF_HOLD = 4'h4;
  localparam logic [3:0] SCR_ADR_SREF = 4'h5;
  localparam logic [3:0] SCR_ADR_MDIV = 4'h6;

  // ----------------------------------------------------------------
  // pin_and_standby_control field positions and reset value
  // ----------------------------------------------------------------
  localparam int SCR_C_OUT_A = 7;
  localparam int SCR_C_OUT_B_XREF = 6;
  localparam int SCR_C_OUT_C = 5;
  localparam int SCR_C_MAIN_FLOAT = 4;
  localparam int SCR_C_SEC_FLOAT = 3;
  localparam int SCR_C_OSC_STBY = 2;
  localparam int SCR_C_MAIN_STBY = 1;
  localparam int SCR_C_SEC_STBY = 0;
  localparam logic [7:0] SCR_C_RESET = 8'h03;

  // ----------------------------------------------------------------
  // main_divider_and_detector fields
  // ----------------------------------------------------------------
  localparam int SCR_N_DIV_W = 18;
  localparam int SCR_N_RATIO = 18;
  localparam int SCR_N_PROG_LO = 19;
  localparam int SCR_N_WINDOW = 22;
  localparam int SCR_N_AUX_TOP = 23;
  localparam logic [23:0] SCR_N_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // secondary reference fields
  // ----------------------------------------------------------------
  localparam int SCR_SREF_MUX_LO = 20;
  localparam logic [23:0] SCR_SREF_RESET = 24'h000000;
  localparam logic [15:0] SCR_HOLD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // decoded settings
  // ----------------------------------------------------------------
  localparam logic [7:0] SCR_WIN_SHORT = 8'h20;
  localparam logic [7:0] SCR_WIN_LONG = 8'h80;
  localparam logic [3:0] SCR_RATIO_LOW = 4'h4;
  localparam logic [3:0] SCR_RATIO_HIGH = 4'h8;
  localparam logic [4:0] SCR_AUX_X2_8 = 5'h10;
  localparam logic [4:0] SCR_AUX_X2_10 = 5'h14;
  localparam logic [4:0] SCR_AUX_X2_12P5 = 5'h19;
  localparam logic [7:0] SCR_BOOST_BASE = 8'h10;
  localparam logic [1:0] SCR_MUX_GPO = 2'h0;

  // register selected by a finished frame
  typedef enum logic [2:0] {
    SCR_SEL_NONE, SCR_SEL_CTRL, SCR_SEL_MREF_HOLD, SCR_SEL_MDIV,
    SCR_SEL_SREF, SCR_SEL_SDIV_HOLD, SCR_SEL_DAC
  } scr_sel_t;

endpackage

/* File: include/scr_ser_if.sv */
`timescale 1ns/1ns
`default_nettype none
// finished serial frame, handed from the receiver to the register core
interface scr_ser_if;
  import scr_pkg::*;
  logic done;
  logic [SCR_LEN_W-1:0] len;
  logic [SCR_FRAME_W-1:0] bits;
  modport rx (output done, output len, output bits);
  modport core (input done, input len, input bits);
endinterface
`default_nettype wire

/* File: src/scr_serial_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module scr_serial_rx
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // serial pins
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_enable_n_i,
  // frame out
  scr_ser_if.rx frame
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r;
  logic sck_d_r, en_d_r;
  logic [SCR_FRAME_W-1:0] shift_r, shift_nxt;
  logic [SCR_LEN_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic sck_rise, en_end;

  // serial clock edges found by the fast clock; pin period must span 4+ cycles
  assign sck_rise = s2_r[2] & ~sck_d_r;
  assign en_end = s2_r[0] & ~en_d_r;

  // shift next state
  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (!s2_r[0] && sck_rise) begin
      shift_nxt = {shift_r[SCR_FRAME_W-2:0], s2_r[1]};
      if (cnt_r != '1) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
    if (en_end) begin
      done_nxt = 1'b1;
    end
    if (done_r) begin
      cnt_nxt = '0;
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 3'h1;
      s2_r <= 3'h1;
      sck_d_r <= 1'b0;
      en_d_r <= 1'b1;
      shift_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      s1_r <= {ser_clk_i, ser_data_i, ser_enable_n_i};
      s2_r <= s1_r;
      sck_d_r <= s2_r[2];
      en_d_r <= s2_r[0];
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign frame.done = done_r;
  assign frame.len = cnt_r;
  assign frame.bits = shift_r;

endmodule
`default_nettype wire

/* File: src/scr_boost_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module scr_boost_timer
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // control
  input wire logic start_i,
  input wire logic [7:0] cycles_i,
  // main reference rate pin
  input wire logic ref_i,
  // high current phase running
  output logic high_phase_o
);

  // ----------------------------------------------------------------
  // reference edge counter
  // ----------------------------------------------------------------
  logic ref_s1_r, ref_s2_r, ref_d_r;
  logic [7:0] left_r, left_nxt;
  logic ref_rise;

  assign ref_rise = ref_s2_r & ~ref_d_r;

  always_comb begin
    left_nxt = left_r;
    if (start_i) begin
      left_nxt = cycles_i;
    end else if (ref_rise && left_r != 8'h00) begin
      left_nxt = left_r - 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_d_r <= 1'b0;
      left_r <= 8'h00;
    end else begin
      ref_s1_r <= ref_i;
      ref_s2_r <= ref_s1_r;
      ref_d_r <= ref_s2_r;
      left_r <= left_nxt;
    end
  end

  assign high_phase_o = (left_r != 8'h00);

endmodule
`default_nettype wire

/* File: tb/scr_synth_regs_props.sv */
`timescale 1ns/1ns
`default_nettype none
module scr_synth_regs_props (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // serial enable
  input wire logic SER_ENABLE_N_I,
  // observed outputs
  input wire logic OUT_A_O,
  input wire logic [1:0] OUT_A_MUX_O,
  input wire logic OUT_B_O,
  input wire logic OUT_B_OE_O,
  input wire logic OUT_C_O,
  input wire logic MAIN_PUMP_HIGH_OE_O,
  input wire logic MAIN_PUMP_LOW_OE_O,
  input wire logic SECONDARY_PUMP_OE_O,
  input wire logic MAIN_STANDBY_O,
  input wire logic SECONDARY_STANDBY_O,
  input wire logic EXT_REF_MODE_O,
  input wire logic [17:0] MAIN_DIV_O,
  input wire logic [15:0] MAIN_REF_DIV_O,
  input wire logic [15:0] SECONDARY_DIV_O,
  input wire logic [7:0] LOCK_WINDOW_O,
  input wire logic [3:0] CURRENT_RATIO_O,
  input wire logic [4:0] AUX_RATIO_X2_O,
  input wire logic AUX_POLARITY_IN_O
);
  // ----------------------------------------------------------------
  // one domain only
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_out_a_ignored: assert property (OUT_A_MUX_O != 2'h0 |-> !OUT_A_O)
    else $error("output A driven outside mux 00");
  a_out_c_low: assert property (OUT_C_O == 1'b0)
    else $error("output C driven high");
  a_out_b_release: assert property (OUT_B_OE_O == !MAIN_STANDBY_O)
    else $error("output B enable disagrees with main standby");
  a_main_pump_off: assert property (MAIN_STANDBY_O |-> !(MAIN_PUMP_HIGH_OE_O || MAIN_PUMP_LOW_OE_O))
    else $error("main pump driving in standby");
  a_sec_pump_off: assert property (SECONDARY_STANDBY_O |-> !SECONDARY_PUMP_OE_O)
    else $error("secondary pump driving in standby");
  a_ext_ref_cause: assert property (EXT_REF_MODE_O |-> AUX_POLARITY_IN_O && OUT_B_O)
    else $error("external reference without pin and bit");
  a_lock_window: assert property (LOCK_WINDOW_O inside {8'h20, 8'h80})
    else $error("lock window not 32 or 128");
  a_current_ratio: assert property (CURRENT_RATIO_O inside {4'h4, 4'h8})
    else $error("current ratio not 4 or 8");
  a_aux_ratio: assert property (AUX_RATIO_X2_O inside {5'h10, 5'h14, 5'h19})
    else $error("aux ratio not 8, 10 or 12.5");
  // dividers only move after a frame ends
  a_div_quiet: assert property (SER_ENABLE_N_I [*8] |=> $stable(MAIN_REF_DIV_O)
    && $stable(SECONDARY_DIV_O) && $stable(MAIN_DIV_O))
    else $error("divider changed without a frame");
endmodule

bind scr_synth_regs scr_synth_regs_props props_u (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I),
  .SER_ENABLE_N_I(SER_ENABLE_N_I), .OUT_A_O(OUT_A_O), .OUT_A_MUX_O(OUT_A_MUX_O),
  .OUT_B_O(OUT_B_O), .OUT_B_OE_O(OUT_B_OE_O), .OUT_C_O(OUT_C_O),
  .MAIN_PUMP_HIGH_OE_O(MAIN_PUMP_HIGH_OE_O), .MAIN_PUMP_LOW_OE_O(MAIN_PUMP_LOW_OE_O),
  .SECONDARY_PUMP_OE_O(SECONDARY_PUMP_OE_O), .MAIN_STANDBY_O(MAIN_STANDBY_O),
  .SECONDARY_STANDBY_O(SECONDARY_STANDBY_O), .EXT_REF_MODE_O(EXT_REF_MODE_O),
  .MAIN_DIV_O(MAIN_DIV_O), .MAIN_REF_DIV_O(MAIN_REF_DIV_O), .SECONDARY_DIV_O(SECONDARY_DIV_O),
  .LOCK_WINDOW_O(LOCK_WINDOW_O), .CURRENT_RATIO_O(CURRENT_RATIO_O),
  .AUX_RATIO_X2_O(AUX_RATIO_X2_O), .AUX_POLARITY_IN_O(AUX_POLARITY_IN_O));
`default_nettype wire

/* File: tb/scr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module scr_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic sck_o,
  output logic sdata_o,
  output logic sen_n_o
);
  // ----------------------------------------------------------------
  // idle: clock parked low, frame closed
  // ----------------------------------------------------------------
  initial begin
    sck_o = 1'b0;
    sdata_o = 1'b0;
    sen_n_o = 1'b1;
  end

  // msb first, framed
  // 160 ns serial period, each level held four system cycles
  task automatic send(input logic [35:0] bits, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      sdata_o <= bits[i];
      sen_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    sen_n_o <= 1'b1;
    sdata_o <= ~sdata_o; // released line must not keep last bit
  endtask
endmodule
`default_nettype wire

/* File: tb/test_synth_control_registers.sv */
`timescale 1ns/1ns
`default_nettype none
module test_synth_control_registers;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, arst_n, mode, sck, sdat, sen_n, oa, ob, ob_oe, oc, oc_oe, phi, plo, spo;
  logic osc_s, main_s, sec_s, xref, pol;
  logic [1:0] oa_mux;
  logic [1:0] rc = 2'h0;
  logic [17:0] mdiv;
  logic [15:0] mref, sdiv, dac;
  logic [23:0] sref;
  logic [7:0] lwin;
  logic [3:0] crat;
  logic [4:0] aux;
  int mismatches = 0;
  int checks = 0;

  scr_host_model host_u (.clk_i(clk), .sck_o(sck), .sdata_o(sdat), .sen_n_o(sen_n));
  scr_synth_regs dut_u (.CLOCK_I(clk), .ARST_N_I(arst_n), .SER_CLK_I(sck), .SER_DATA_I(sdat),
    .SER_ENABLE_N_I(sen_n), .MODE_I(mode), .MAIN_REF_RATE_I(rc[1]), .OUT_A_O(oa),
    .OUT_A_MUX_O(oa_mux), .OUT_B_O(ob), .OUT_B_OE_O(ob_oe), .OUT_C_O(oc), .OUT_C_OE_O(oc_oe),
    .MAIN_PUMP_HIGH_OE_O(phi), .MAIN_PUMP_LOW_OE_O(plo), .SECONDARY_PUMP_OE_O(spo),
    .OSC_STANDBY_O(osc_s), .MAIN_STANDBY_O(main_s), .SECONDARY_STANDBY_O(sec_s),
    .EXT_REF_MODE_O(xref), .MAIN_DIV_O(mdiv), .MAIN_REF_DIV_O(mref), .SECONDARY_DIV_O(sdiv),
    .SECONDARY_REF_O(sref), .DAC_VALUES_O(dac), .LOCK_WINDOW_O(lwin), .CURRENT_RATIO_O(crat),
    .AUX_RATIO_X2_O(aux), .AUX_POLARITY_IN_O(pol));

  // clock and a free running reference rate, one rise every 4 cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) rc <= rc + 2'h1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // frame, then room for the 5 cycle update and the enable gap
  task automatic wr(input logic [35:0] b, input int n);
    host_u.send(b, n);
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("out_a", 0, oa);
    chk("out_c_oe", 1, oc_oe);
    chk("pumps", 0, {phi, plo, spo});
    chk("osc_stby", 0, osc_s);
    chk("main_stby", 1, main_s);
    chk("sec_stby", 1, sec_s);
    chk("out_b_oe", 0, ob_oe);
    chk("lock_win", 8'h20, lwin);
    chk("cur_ratio", 4'h4, crat);
    chk("aux", 5'h14, aux);
  endtask
  task automatic t_buffer;
    wr(16'h1e60, 16);
    chk("mref_held", 0, mref);
    wr({16'h1388, 4'h3}, 20);
    chk("sdiv_held", 0, sdiv);
    wr({16'habcd, 4'h2}, 20);
    chk("dac", 16'habcd, dac);
    wr({1'b1, 1'b1, 3'b011, 1'b1, 18'h00f28}, 24);
    chk("mdiv", 18'h00f28, mdiv);
    chk("mref", 16'h1e60, mref);
    chk("sdiv", 16'h1388, sdiv);
    chk("lock_win", 8'h80, lwin);
    chk("cur_ratio", 4'h8, crat);
    chk("aux", 5'h10, aux);
    wr({16'h07d0, 4'h4}, 20);
    chk("mref_wait", 16'h1e60, mref);
    // pumps statically on, aux top set ahead of the control scenario
    wr({24'h980123, 4'h6}, 28);
    chk("mdiv_adr", 18'h00123, mdiv);
    chk("mref_adr", 16'h07d0, mref);
    // control address with a 16 bit body must be dropped
    wr({16'h0000, 4'h1}, 20);
    chk("refused", 1, main_s);
  endtask
  task automatic t_control;
    wr(8'hb0, 8);
    chk("out_a", 1, oa);
    chk("out_c_oe", 0, oc_oe);
    chk("main_float", 0, {phi, plo});
    chk("sec_pump", 1, spo);
    chk("stby", 0, {main_s, sec_s});
    chk("out_b_oe", 1, ob_oe);
    wr({8'h08, 4'h1}, 12);
    chk("sec_float", 0, spo);
    chk("out_a_low", 0, oa);
    chk("main_float", 2'h3, {phi, plo});
    wr(8'h47, 8);
    chk("osc_stby", 1, osc_s);
    chk("stby_all", 2'h3, {main_s, sec_s});
    chk("out_b_oe", 0, ob_oe);
  endtask
  task automatic t_mode;
    for (int i = 0; i < 4; i++) begin
      mode <= i[1];
      wr({1'b0, i[0], 6'h00}, 8);
      chk("ext_ref", i[1] & i[0], xref);
      chk("out_b", {i[0], 1'b1}, {ob, ob_oe});
      chk("polarity", i[1], pol);
    end
    mode <= 1'b0;
  endtask
  task automatic t_prog;
    for (int p = 0; p < 8; p++) begin
      wr({2'b00, p[2:0], 1'b0, 18'h003e8}, 24);
      if (p < 4) begin
        chk("static", p[1:0], {phi, plo});
      end else begin
        chk("timed_start", 2'h2, {phi, plo});
        repeat (((16 << (p - 4)) * 4) - 16) @(posedge clk);
        chk("timed_mid", 2'h2, {phi, plo});
        repeat (24) @(posedge clk);
        chk("timed_end", 2'h1, {phi, plo});
      end
    end
  endtask
  task automatic t_aux;
    wr(8'h80, 8);
    for (int i = 0; i < 8; i++) begin
      wr({i[2], 5'h00, 18'h003e8}, 24);
      wr({8'h00, 4'h1, 18'h00000, i[1:0]}, 32);
      chk("sref", {4'h1, 18'h00000, i[1:0]}, sref);
      chk("aux", i[2] ? (i[1:0] == 0 ? 5'h10 : 5'h14) : (i[1:0] == 0 ? 5'h14 : 5'h19), aux);
      chk("out_a_mux", 3'h2, {oa_mux, oa});
    end
    wr({32'h0, 4'h5}, 36);
    chk("sref_adr", 0, sref);
    chk("out_a_gpo", 1, oa);
    chk("mref_kept", 16'h07d0, mref);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    mode = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_buffer();
    t_control();
    t_mode();
    wr(8'h00, 8);
    t_prog();
    t_aux();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
